// *** dhpi_top.sv ***
// Host pin interface of a display controller: parallel, serial and I2C pins.
// What this block does
// - E-strobe mode: direction high reads, low writes
// - E-strobe operation only while enable high, selected
// - Write-strobe low with select begins a write
// - Read-strobe low with select drives data bus
// - Sixteen data pins (eight in 8-bit modes) sampled on writes, driven reads
// - Serial: bit 0 clock, bit 1 data
// - I2C: bit 0 clock, bit 1 data
// - Frame sync output follows refresh timing
// - Data/command low is command, high data
// - E-strobe data latched on enable falling edge
// - Write-strobe rising edge latches the word
// - First display read after write returns stale
module dhpi_top (
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    input  wire logic [2:0]    mode_sel,
    input  wire logic [15:0]   data_in,
    output logic      [15:0]   data_out,
    output logic      [15:0]   data_oe,
    input  wire logic          en_rd_in,
    input  wire logic          rw_wr_in,
    input  wire logic          cs_n_in,
    input  wire logic          dc_in,
    output logic               frame_sync_out,
    output logic               i2c_clk_in,
    output logic               i2c_sda_in,
    output logic               xfer_valid,
    input  wire logic          xfer_ready,
    output logic      [16:0]   xfer_data,
    input  wire logic [15:0]   rd_word,
    output logic               rd_take
);
    typedef struct packed
    {
        dhpi_pkg::dhpi_pins_type s1;
        dhpi_pkg::dhpi_pins_type s2;
        dhpi_pkg::dhpi_pins_type s3;
        logic                    mode_ok;
        logic [2:0]              mode;
        logic [7:0]              shift;
        logic [3:0]              bits;
        logic                    dc_bit;
        logic                    push;
        dhpi_pkg::dhpi_xfer_type xfer;
        logic                    reading;
        logic                    dummy_pend;
        logic [15:0]             rd_q;
        logic                    rd_take;
        logic [11:0]             fcnt;
        logic                    fsync;
    } dhpi_state_type;

    // Pins reset to an idle, deselected bus; all-zero stages would look
    // selected for two cycles after reset and start a false read.
    localparam dhpi_pkg::dhpi_pins_type PINS_IDLE =
        '{data: dhpi_pkg::WORD_ZERO, cs_n: 1'b1, default: 1'b0};
    localparam dhpi_state_type ST_RESET =
        '{s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE, default: '0};

    dhpi_state_type          st_q;
    dhpi_state_type          st_d;
    dhpi_pkg::dhpi_pins_type pins;
    dhpi_pkg::dhpi_mode_type mode;
    logic                    fifo_ready;
    logic                    par_e;
    logic                    par_rw;
    logic                    serial;
    logic                    sel;

    // Pins gathered into one bundle for the synchroniser.
    assign pins.data  = data_in;
    assign pins.en_rd = en_rd_in;
    assign pins.rw_wr = rw_wr_in;
    assign pins.cs_n  = cs_n_in;
    assign pins.dc    = dc_in;

    assign mode   = dhpi_pkg::dhpi_mode_type'(st_q.mode);
    assign par_e  = (mode == dhpi_pkg::MODE_P8_E)
                  || (mode == dhpi_pkg::MODE_P16_E);
    assign par_rw = (mode == dhpi_pkg::MODE_P8_RW)
                  || (mode == dhpi_pkg::MODE_P16_RW);
    assign serial = (mode == dhpi_pkg::MODE_SPI4)
                  || (mode == dhpi_pkg::MODE_SPI3);
    assign sel    = !st_q.s2.cs_n;

    // Width mask: the 8-bit modes only use the low byte.
    function automatic logic [15:0] bus_word(input logic [15:0] w,
                                             input logic [2:0]  m);
        if (m == dhpi_pkg::MODE_P8_E || m == dhpi_pkg::MODE_P8_RW)
            return {dhpi_pkg::BYTE_ZERO, w[7:0]};
        return w;
    endfunction

    // Next-state logic for all transfer paths and the frame timer.
    always_comb
    begin
        st_d         = st_q;
        st_d.s1      = pins;
        st_d.s2      = st_q.s1;
        st_d.s3      = st_q.s2;
        st_d.push    = 1'b0;
        st_d.rd_take = 1'b0;
        if (!st_q.mode_ok)
        begin
            st_d.mode    = mode_sel;
            st_d.mode_ok = 1'b1;
        end
        if (sel && st_q.mode_ok && fifo_ready)
        begin
            if (par_e)
            begin
                if (st_q.s3.en_rd && !st_q.s2.en_rd)
                begin
                    if (!st_q.s2.rw_wr)
                    begin
                        st_d.push         = 1'b1;
                        st_d.xfer.is_data = st_q.s2.dc;
                        st_d.xfer.word    = bus_word(st_q.s2.data, st_q.mode);
                        st_d.dummy_pend   = 1'b1;
                    end
                    else
                        st_d.reading = 1'b0;
                end
                if (st_q.s2.en_rd && st_q.s2.rw_wr && !st_q.reading)
                begin
                    st_d.reading = 1'b1;
                    st_d.rd_q    = st_q.dummy_pend ? dhpi_pkg::STALE_WORD
                                 : bus_word(rd_word, st_q.mode);
                    st_d.rd_take = !st_q.dummy_pend;
                    st_d.dummy_pend = 1'b0;
                end
            end
            else if (par_rw)
            begin
                if (!st_q.s3.rw_wr && st_q.s2.rw_wr)
                begin
                    st_d.push         = 1'b1;
                    st_d.xfer.is_data = st_q.s2.dc;
                    st_d.xfer.word    = bus_word(st_q.s2.data, st_q.mode);
                    st_d.dummy_pend   = 1'b1;
                end
                if (!st_q.s2.en_rd && !st_q.reading)
                begin
                    st_d.reading = 1'b1;
                    st_d.rd_q    = st_q.dummy_pend ? dhpi_pkg::STALE_WORD
                                 : bus_word(rd_word, st_q.mode);
                    st_d.rd_take = !st_q.dummy_pend;
                    // A write latched in this same cycle keeps the flag set.
                    st_d.dummy_pend = st_d.push;
                end
                else if (st_q.s2.en_rd)
                    st_d.reading = 1'b0;
            end
            else if (serial)
            begin
                if (!st_q.s3.data[dhpi_pkg::SCK_BIT]
                    && st_q.s2.data[dhpi_pkg::SCK_BIT])
                begin
                    if (mode == dhpi_pkg::MODE_SPI3
                        && st_q.bits == dhpi_pkg::BIT_CNT_0)
                        st_d.dc_bit = st_q.s2.data[dhpi_pkg::SDI_BIT];
                    else
                        st_d.shift = {st_q.shift[6:0],
                                      st_q.s2.data[dhpi_pkg::SDI_BIT]};
                    st_d.bits = st_q.bits + dhpi_pkg::BIT_CNT_1;
                    if (int'(st_q.bits) == ((mode == dhpi_pkg::MODE_SPI3)
                        ? dhpi_pkg::SPI3_BITS : dhpi_pkg::SPI4_BITS) - 1)
                    begin
                        st_d.bits         = dhpi_pkg::BIT_CNT_0;
                        st_d.push         = 1'b1;
                        st_d.xfer.is_data = (mode == dhpi_pkg::MODE_SPI3)
                                          ? st_q.dc_bit : st_q.s2.dc;
                        st_d.xfer.word    = {dhpi_pkg::BYTE_ZERO,
                                             st_q.shift[6:0],
                                             st_q.s2.data[dhpi_pkg::SDI_BIT]};
                    end
                end
            end
        end
        if (!sel)
        begin
            st_d.reading = 1'b0;
            st_d.bits    = dhpi_pkg::BIT_CNT_0;
        end
        st_d.fcnt  = (st_q.fcnt == dhpi_pkg::FRAME_LAST)
                   ? dhpi_pkg::CNT_ZERO : st_q.fcnt + 12'h001;
        st_d.fsync = (st_q.fcnt < dhpi_pkg::SYNC_LAST);
    end

    // Single state register.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            st_q <= ST_RESET;
        else
            st_q <= st_d;
    end

    // drive data pins on reads only
    assign data_out       = st_q.rd_q;
    assign data_oe        = (st_q.reading && sel && (par_e || par_rw))
                          ? bus_word(16'hFFFF, st_q.mode)
                          : dhpi_pkg::WORD_ZERO;
    assign frame_sync_out = st_q.fsync;
    assign rd_take        = st_q.rd_take;
    // I2C pin roles for a separate engine
    assign i2c_clk_in     = (mode == dhpi_pkg::MODE_I2C)
                          && st_q.s2.data[dhpi_pkg::SCK_BIT];
    assign i2c_sda_in     = (mode == dhpi_pkg::MODE_I2C)
                          && st_q.s2.data[dhpi_pkg::SDI_BIT];

    // Transfer buffer; a full buffer stalls strobe decoding.
    dhpi_fifo #(
        .WIDTH (dhpi_pkg::XFER_W),
        .DEPTH (dhpi_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (st_q.push),
        .in_ready  (fifo_ready),
        .in_data   (st_q.xfer),
        .out_valid (xfer_valid),
        .out_ready (xfer_ready),
        .out_data  (xfer_data)
    );

    // Frame sync pulse holds for at least eight cycles.
    a_fsync_width: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(frame_sync_out) |-> frame_sync_out [*8])
        else $error("frame sync too short");
    // No drive while deselected.
    a_desel_float: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        st_q.s3.cs_n && st_q.s2.cs_n |=> data_oe == dhpi_pkg::WORD_ZERO)
        else $error("data driven while deselected");
    // Write strobe edge produces a push.
    a_wr_push: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        par_rw && sel && fifo_ready && !st_q.s3.rw_wr && st_q.s2.rw_wr
        |=> st_q.push)
        else $error("write edge not latched");
    // Mode stays fixed once captured.
    a_mode_fixed: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        st_q.mode_ok |=> $stable(st_q.mode))
        else $error("mode changed while running");
    // A read starts when the strobes ask for one and none is in flight.
    sequence s_rd_start;
        st_q.mode_ok && sel && fifo_ready && !st_q.reading
        && ((par_rw && !st_q.s2.en_rd)
            || (par_e && st_q.s2.en_rd && st_q.s2.rw_wr));
    endsequence
    // A requested read turns the bus around.
    a_read_drive: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        s_rd_start |=> st_q.reading)
        else $error("read strobe did not start a read");
    // The first read after a write hands back the stale word.
    a_dummy_stale: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        s_rd_start ##0 st_q.dummy_pend
        |=> st_q.rd_q == dhpi_pkg::STALE_WORD && !st_q.rd_take)
        else $error("first read after a write was not stale");
    // Enable falling with write direction latches a word.
    a_e_latch: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        par_e && sel && st_q.mode_ok && fifo_ready && st_q.s3.en_rd
        && !st_q.s2.en_rd && !st_q.s2.rw_wr |=> st_q.push)
        else $error("enable fall did not latch a write");

endmodule

// *** dhpi_pkg.sv ***
// Package of types and constants for the display host pin interface.
package dhpi_pkg;

    // Bus mode selection, fixed while running.
    typedef enum logic [2:0]
    {
        MODE_P8_E,
        MODE_P16_E,
        MODE_P8_RW,
        MODE_P16_RW,
        MODE_SPI4,
        MODE_SPI3,
        MODE_I2C
    } dhpi_mode_type;

    // Transfer kind seen by the core.
    typedef struct packed
    {
        logic        is_data;
        logic [15:0] word;
    } dhpi_xfer_type;

    localparam int          DATA_W      = 16;
    localparam int          XFER_W      = 17;
    localparam int          FIFO_DEPTH  = 16;
    localparam int          SPI4_BITS   = 8;
    localparam int          SPI3_BITS   = 9;
    localparam logic [3:0]  BIT_CNT_0   = 4'h0;
    localparam logic [3:0]  BIT_CNT_1   = 4'h1;
    localparam int          SCK_BIT     = 0;
    localparam int          SDI_BIT     = 1;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    localparam logic [15:0] WORD_ZERO   = 16'h0000;
    localparam logic [15:0] STALE_WORD  = 16'h0000;
    // Frame sync timing, in cycles of clk_sys.
    localparam int          FRAME_CYCLES = 4000;
    localparam int          SYNC_CYCLES  = 40;
    localparam logic [11:0] FRAME_LAST   = 12'(FRAME_CYCLES - 1);
    localparam logic [11:0] SYNC_LAST    = 12'(SYNC_CYCLES);
    localparam logic [11:0] CNT_ZERO     = 12'h000;

    // Two-stage synchroniser state for the pins.
    typedef struct packed
    {
        logic [15:0] data;
        logic        en_rd;
        logic        rw_wr;
        logic        cs_n;
        logic        dc;
    } dhpi_pins_type;

endpackage

// *** dhpi_fifo.sv ***
// Parameterised FIFO that buffers host transfers toward the core.
module dhpi_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } dhpi_fptr_type;

    logic [WIDTH-1:0] mem [DEPTH];
    dhpi_fptr_type    st_q;
    dhpi_fptr_type    st_d;
    logic             full;
    logic             empty;

    // Full and empty come from the extra wrap bit of each pointer.
    assign empty     = (st_q.wr == st_q.rd);
    assign full      = (st_q.wr[AW] != st_q.rd[AW])
                     && (st_q.wr[AW-1:0] == st_q.rd[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[st_q.rd[AW-1:0]];

    // Pointer advance on each accepted push or pop.
    always_comb
    begin
        st_d = st_q;
        if (in_valid && !full)
            st_d.wr = st_q.wr + 1'b1;
        if (out_ready && !empty)
            st_d.rd = st_q.rd + 1'b1;
    end

    // Storage array; no reset needed on the data itself.
    always_ff @(posedge clk_sys)
    begin
        if (in_valid && !full)
            mem[st_q.wr[AW-1:0]] <= in_data;
    end

    // Pointer register.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

endmodule

// *** dhpi_host_model.sv ***
// Host controller model that drives the display pin interface.
module dhpi_host_model (
    input  wire logic        clk_sys,
    input  wire logic [15:0] bus,
    input  wire logic [15:0] oe,
    output logic             e_rd,
    output logic             rw_wr,
    output logic             cs_n,
    output logic             dc,
    output logic [15:0]      d_host,
    output logic             d_en
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle levels at time zero suit the separate-strobe style.
    initial
    begin
        {e_rd, rw_wr, cs_n, dc, d_en} = 5'h1D;
        d_host = 16'h0000;
    end

    // Every strobe phase but the eight-edge read setup lasts four edges, the least the pins allow.
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Idle strobe levels differ by mode, so the bench chooses them.
    task automatic park(input logic e, input logic r);
        e_rd  <= e;
        rw_wr <= r;
        cs_n  <= 1'b1;
    endtask

    // write direction and kind
    // A parallel write; em picks the enable-strobe style.
    task automatic wr(input logic em, input logic sel_n, input logic c,
                      input logic [15:0] w);
        cs_n   <= sel_n;
        dc     <= c;
        d_host <= w;
        d_en   <= 1'b1;
        e_rd   <= 1'b1;
        rw_wr  <= 1'b0;
        step(4);
        if (em)
            e_rd <= 1'b0;
        else
            rw_wr <= 1'b1;
        step(4);
        cs_n <= 1'b1;
        d_en <= 1'b0;
        step(4);
    endtask

    // read sampled while strobe active
    // A parallel read; em picks the enable-strobe style, the bus is released.
    task automatic rd(input logic em, output logic [15:0] w,
                      output logic [15:0] o);
        @(posedge clk_sys);
        cs_n  <= 1'b0;
        d_en  <= 1'b0;
        e_rd  <= em;
        rw_wr <= 1'b1;
        step(8);
        @(negedge clk_sys);
        w = bus;
        o = oe;
        @(posedge clk_sys);
        e_rd <= !em;
        step(4);
        cs_n <= 1'b1;
        step(4);
    endtask

    // strobes grounded, spare pins low
    // Serial frame of n bits, MSB first; the clock rests low between frames.
    task automatic spi(input int n, input logic [8:0] v, input logic c);
        e_rd   <= 1'b0;
        rw_wr  <= 1'b0;
        cs_n   <= 1'b0;
        dc     <= c;
        d_en   <= 1'b1;
        d_host <= 16'h0000;
        step(4);
        for (int i = n - 1; i >= 0; i--)
        begin
            d_host[1:0] <= {v[i], 1'b0};
            step(4);
            d_host[0] <= 1'b1;
            step(4);
        end
        d_host[0] <= 1'b0;
        step(4);
        cs_n <= 1'b1;
        step(4);
    endtask

    // Drives the data lines as plain levels for the two-wire mode.
    task automatic lines(input logic [15:0] v);
        @(posedge clk_sys);
        d_host <= v;
        d_en   <= 1'b1;
    endtask
endmodule

// *** tb_dhpi_top.sv ***
// Self-checking testbench for the display host pin interface.
module tb_dhpi_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys, sys_rst, xfer_valid, xfer_ready, rd_take;
    logic        frame_sync_out, i2c_clk_in, i2c_sda_in;
    logic        e_rd, rw_wr, cs_n, dc, d_en;
    logic [2:0]  mode_sel;
    logic [15:0] bus, data_out, data_oe, d_host, rd_word, w, o;
    logic [16:0] xfer_data, take_cnt, t0;
    int          num_errors, compares;

    // A released bus shows the inverse of its last value, never a hold.
    assign bus = (data_oe & data_out) | (~data_oe & (d_en ? d_host : ~d_host));

    dhpi_top dut (
        .clk_sys        (clk_sys),
        .sys_rst        (sys_rst),
        .mode_sel       (mode_sel),
        .data_in        (bus),
        .data_out       (data_out),
        .data_oe        (data_oe),
        .en_rd_in       (e_rd),
        .rw_wr_in       (rw_wr),
        .cs_n_in        (cs_n),
        .dc_in          (dc),
        .frame_sync_out (frame_sync_out),
        .i2c_clk_in     (i2c_clk_in),
        .i2c_sda_in     (i2c_sda_in),
        .xfer_valid     (xfer_valid),
        .xfer_ready     (xfer_ready),
        .xfer_data      (xfer_data),
        .rd_word        (rd_word),
        .rd_take        (rd_take)
    );

    dhpi_host_model host (
        .clk_sys (clk_sys),
        .bus     (bus),
        .oe      (data_oe),
        .e_rd    (e_rd),
        .rw_wr   (rw_wr),
        .cs_n    (cs_n),
        .dc      (dc),
        .d_host  (d_host),
        .d_en    (d_en)
    );

    // Free-running 50 ns clock.
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Counts read-consumed pulses so scenarios can compare deltas.
    initial take_cnt = 17'h00000;
    always @(posedge clk_sys)
        if (rd_take === 1'b1)
            take_cnt <= take_cnt + 17'h00001;

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t ns: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // A wait that runs out is a failure in itself.
    task automatic hang();
        check(17'h00001, 17'h00000);
        conclude();
    endtask

    // Mode is only taken at reset release, so each mode gets a fresh reset.
    task automatic start(input dhpi_pkg::dhpi_mode_type m, input logic e,
                         input logic r);
        @(posedge clk_sys);
        mode_sel <= m;
        sys_rst  <= 1'b1;
        host.park(e, r);
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (5) @(posedge clk_sys);
    endtask

    // Waits for a buffered transfer, compares it and pops it.
    task automatic pop(input logic [16:0] exp);
        int n;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
            if (n > 40)
                hang();
        end
        while (xfer_valid !== 1'b1);
        check(xfer_data, exp);
        @(posedge clk_sys);
        xfer_ready <= 1'b1;
        @(posedge clk_sys);
        xfer_ready <= 1'b0;
    endtask

    // Writes pile up while the core stalls; a deselected one must vanish.
    task automatic t_write_rw();
        start(dhpi_pkg::MODE_P16_RW, 1'b1, 1'b1);
        host.wr(1'b0, 1'b0, 1'b1, 16'hA5C3);
        host.wr(1'b0, 1'b0, 1'b0, 16'h0102);
        host.wr(1'b0, 1'b1, 1'b1, 16'hFFFF);
        host.wr(1'b0, 1'b0, 1'b1, 16'h8000);
        pop(17'h1A5C3);
        pop(17'h00102);
        pop(17'h18000);
        repeat (10) @(negedge clk_sys);
        check({16'h0000, xfer_valid}, 17'h00000);
    endtask

    // The first read after a write is a dummy; the next one is real.
    task automatic t_read_rw();
        t0 = take_cnt;
        host.rd(1'b0, w, o);
        check({1'b0, o}, 17'h0FFFF);
        check({1'b0, w}, {1'b0, dhpi_pkg::STALE_WORD});
        check(take_cnt, t0);
        host.rd(1'b0, w, o);
        check({1'b0, w}, 17'h05AF0);
        check(take_cnt, t0 + 17'h00001);
        check({1'b0, data_oe}, 17'h00000);
    endtask

    // Enable-strobe write, latched on the falling edge of the enable.
    task automatic t_write_e();
        start(dhpi_pkg::MODE_P8_E, 1'b0, 1'b0);
        host.wr(1'b1, 1'b0, 1'b0, 16'h003C);
        pop(17'h0003C);
        t0 = take_cnt;
        host.rd(1'b1, w, o);
        check({1'b0, o}, 17'h000FF);
        check({9'h000, w[7:0]}, {9'h000, dhpi_pkg::STALE_WORD[7:0]});
        host.rd(1'b1, w, o);
        check({9'h000, w[7:0]}, 17'h000F0);
        check(take_cnt, t0 + 17'h00001);
    endtask

    // Full-width enable-strobe data write, then a dummy and a real read.
    task automatic t_read_e();
        start(dhpi_pkg::MODE_P16_E, 1'b0, 1'b0);
        host.wr(1'b1, 1'b0, 1'b1, 16'hC3A5);
        pop(17'h1C3A5);
        host.rd(1'b1, w, o);
        host.rd(1'b1, w, o);
        check({1'b0, o}, 17'h0FFFF);
        check({1'b0, w}, 17'h05AF0);
    endtask

    // Byte-wide separate-strobe write lands in the low byte.
    task automatic t_narrow_rw();
        start(dhpi_pkg::MODE_P8_RW, 1'b1, 1'b1);
        host.wr(1'b0, 1'b0, 1'b1, 16'h00AB);
        pop(17'h100AB);
    endtask

    // Both serial formats: 4-wire with the pin, 3-wire with a leading bit.
    task automatic t_serial();
        start(dhpi_pkg::MODE_SPI4, 1'b0, 1'b0);
        host.spi(8, 9'h096, 1'b1);
        pop(17'h10096);
        start(dhpi_pkg::MODE_SPI3, 1'b0, 1'b0);
        host.spi(9, 9'h169, 1'b0);
        pop(17'h10069);
    endtask

    // Two-wire mode only exposes its lines; both levels must get through.
    task automatic t_two_wire();
        start(dhpi_pkg::MODE_I2C, 1'b0, 1'b0);
        host.lines(16'h0001);
        repeat (6) @(negedge clk_sys);
        check({15'h0000, i2c_clk_in, i2c_sda_in}, 17'h00002);
        host.lines(16'h0002);
        repeat (6) @(negedge clk_sys);
        check({15'h0000, i2c_clk_in, i2c_sda_in}, 17'h00001);
    endtask

    // Any whole frame period holds exactly SYNC_CYCLES cycles of sync high.
    task automatic t_frame();
        int hi;
        hi = 0;
        repeat (dhpi_pkg::FRAME_CYCLES)
        begin
            @(negedge clk_sys);
            if (frame_sync_out === 1'b1)
                hi++;
        end
        check(17'(hi), 17'(dhpi_pkg::SYNC_CYCLES));
    endtask

    initial
    begin
        sys_rst    = 1'b1;
        mode_sel   = 3'h0;
        xfer_ready = 1'b0;
        rd_word    = 16'h5AF0;
        num_errors = 0;
        compares   = 0;
        t_write_rw();
        t_read_rw();
        t_write_e();
        t_read_e();
        t_narrow_rw();
        t_serial();
        t_two_wire();
        t_frame();
        conclude();
    end
endmodule
